//--- timer_two_pkg.sv
// Constants for the rate-controlled 16-bit timer block
package timer_two_pkg;
    // Special-function register addresses
    localparam logic [7:0] ADDR_RATE_SELECT = 8'h8e;
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
    // Control register bit positions
    localparam int CTL_OVERFLOW_FLAG = 7;
    localparam int CTL_EXT_EDGE_FLAG = 6;
    localparam int CTL_RX_BAUD_SELECT = 5;
    localparam int CTL_TX_BAUD_SELECT = 4;
    localparam int CTL_EXT_EDGE_ENABLE = 3;
    localparam int CTL_RUN_CONTROL = 2;
    localparam int CTL_COUNT_SOURCE = 1;
    localparam int CTL_CAPTURE_RELOAD = 0;
    // Rate select bit positions
    localparam int RATE_UPPER_TIMER = 5;
    localparam int RATE_MID_TIMER = 4;
    localparam int RATE_FIRST_TIMER = 3;
    localparam logic [7:0] RATE_WRITE_MASK = 8'h38;
    // Reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_RATE_SELECT = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
    localparam logic [15:0] RESET_RELOAD = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    // Prescaler: clocks per increment
    localparam int CLOCKS_SLOW = 12;
    localparam int CLOCKS_FAST = 4;
    localparam int CLOCKS_BAUD = 2;
    localparam logic [3:0] PRE_LAST = 4'(CLOCKS_SLOW - 1);
    localparam logic [1:0] PRE_FAST_LAST = 2'(CLOCKS_FAST - 1);
endpackage

//--- timer_two.sv
// Timer with auto-reload, capture, baud generation and timer rate control
`timescale 1ns/1ns
module timer_two (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic sfr_sel_out,
    output logic [7:0] sfr_rdata_out,
    input wire logic ext_count_input_in,
    input wire logic ext_trigger_input_in,
    input wire logic timer1_overflow_in,
    input wire logic irq_enable_in,
    output logic timer_irq_out,
    output logic overflow_pulse_out,
    output logic rx_shift_clk_out,
    output logic tx_shift_clk_out,
    output logic timer0_tick_out,
    output logic timer1_tick_out
);
    logic [7:0] ctl_q;
    logic [7:0] rate_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] reload_q;
    logic [15:0] reload_d;
    logic [3:0] pre_q;
    logic ct_s1_q, ct_s2_q, ct_s3_q;
    logic tg_s1_q, tg_s2_q, tg_s3_q;
    logic ovf_pulse_q, rx_q, tx_q, t0_q, t1_q;
    logic [7:0] rdata_q;

    // Register decode
    wire wr_ctl = sfr_wr_in && (sfr_addr_in == timer_two_pkg::ADDR_CONTROL);
    wire wr_rate = sfr_wr_in && (sfr_addr_in == timer_two_pkg::ADDR_RATE_SELECT);
    wire wr_rl = sfr_wr_in && (sfr_addr_in == timer_two_pkg::ADDR_RELOAD_LOW);
    wire wr_rh = sfr_wr_in && (sfr_addr_in == timer_two_pkg::ADDR_RELOAD_HIGH);
    wire wr_cl = sfr_wr_in && (sfr_addr_in == timer_two_pkg::ADDR_COUNT_LOW);
    wire wr_ch = sfr_wr_in && (sfr_addr_in == timer_two_pkg::ADDR_COUNT_HIGH);
    wire wr_count = wr_cl || wr_ch;

    // Control fields
    wire ovf_flag = ctl_q[timer_two_pkg::CTL_OVERFLOW_FLAG];
    wire edge_flag = ctl_q[timer_two_pkg::CTL_EXT_EDGE_FLAG];
    wire rx_sel = ctl_q[timer_two_pkg::CTL_RX_BAUD_SELECT];
    wire tx_sel = ctl_q[timer_two_pkg::CTL_TX_BAUD_SELECT];
    wire edge_en = ctl_q[timer_two_pkg::CTL_EXT_EDGE_ENABLE];
    wire run = ctl_q[timer_two_pkg::CTL_RUN_CONTROL];
    wire src_sel = ctl_q[timer_two_pkg::CTL_COUNT_SOURCE];
    wire cap_sel = ctl_q[timer_two_pkg::CTL_CAPTURE_RELOAD];
    wire upper_fast = rate_q[timer_two_pkg::RATE_UPPER_TIMER];
    wire t1_fast = rate_q[timer_two_pkg::RATE_MID_TIMER];
    wire t0_fast = rate_q[timer_two_pkg::RATE_FIRST_TIMER];

    // Prescaler taps
    wire tick12 = (pre_q == timer_two_pkg::PRE_LAST);
    wire tick4 = (pre_q[1:0] == timer_two_pkg::PRE_FAST_LAST);
    wire tick2 = pre_q[0];

    // Synchronised falling edges
    wire count_fall = ct_s3_q && !ct_s2_q;
    wire trig_fall = tg_s3_q && !tg_s2_q;

    // Mode and increment
    wire baud = rx_sel || tx_sel;
    wire reload_mode = baud || !cap_sel;
    wire int_tick = baud ? tick2 : (upper_fast ? tick4 : tick12);
    wire inc = run && (src_sel ? count_fall : int_tick);
    wire ovf = inc && (count_q == timer_two_pkg::COUNT_ALL_ONES);
    wire edge_hit = edge_en && trig_fall;
    wire force_reload = edge_hit && reload_mode;
    wire capture = edge_hit && !reload_mode;
    wire flag_set = ovf && !baud;

    // Count next value: software write, forced reload, overflow, increment
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = count_q;
            if (wr_cl) begin
                count_d[7:0] = sfr_wdata_in;
            end
            if (wr_ch) begin
                count_d[15:8] = sfr_wdata_in;
            end
        end else if (force_reload) begin
            count_d = reload_q;
        end else if (ovf && reload_mode) begin
            count_d = reload_q;
        end else if (inc) begin
            count_d = count_q + 16'h0001;
        end
    end

    // Reload bytes: software write or capture of the count
    always_comb begin
        reload_d = reload_q;
        if (capture) begin
            reload_d = count_q;
        end
        if (wr_rl) begin
            reload_d[7:0] = sfr_wdata_in;
        end
        if (wr_rh) begin
            reload_d[15:8] = sfr_wdata_in;
        end
    end

    // Control next value; hardware set wins over software clear
    wire [7:0] ctl_base = wr_ctl ? sfr_wdata_in : ctl_q;
    wire [7:0] ctl_d = {ctl_base[7] || flag_set, ctl_base[6] || edge_hit, ctl_base[5:0]};
    wire [7:0] rate_d = wr_rate ? (sfr_wdata_in & timer_two_pkg::RATE_WRITE_MASK) : rate_q;

    // Read mux
    wire sel_any = (sfr_addr_in == timer_two_pkg::ADDR_CONTROL)
        || (sfr_addr_in == timer_two_pkg::ADDR_RATE_SELECT)
        || (sfr_addr_in == timer_two_pkg::ADDR_RELOAD_LOW)
        || (sfr_addr_in == timer_two_pkg::ADDR_RELOAD_HIGH)
        || (sfr_addr_in == timer_two_pkg::ADDR_COUNT_LOW)
        || (sfr_addr_in == timer_two_pkg::ADDR_COUNT_HIGH);
    wire [7:0] rd_mux =
        (sfr_addr_in == timer_two_pkg::ADDR_CONTROL) ? ctl_q :
        (sfr_addr_in == timer_two_pkg::ADDR_RATE_SELECT) ? rate_q :
        (sfr_addr_in == timer_two_pkg::ADDR_RELOAD_LOW) ? reload_q[7:0] :
        (sfr_addr_in == timer_two_pkg::ADDR_RELOAD_HIGH) ? reload_q[15:8] :
        (sfr_addr_in == timer_two_pkg::ADDR_COUNT_LOW) ? count_q[7:0] :
        (sfr_addr_in == timer_two_pkg::ADDR_COUNT_HIGH) ? count_q[15:8] : 8'h00;

    // Pulse sources
    wire rx_d = rx_sel ? ovf : timer1_overflow_in;
    wire tx_d = tx_sel ? ovf : timer1_overflow_in;
    wire t1_d = t1_fast ? tick4 : tick12;
    wire t0_d = t0_fast ? tick4 : tick12;
    wire [3:0] pre_d = tick12 ? 4'h0 : pre_q + 4'h1;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_q <= timer_two_pkg::RESET_CONTROL;
            rate_q <= timer_two_pkg::RESET_RATE_SELECT;
            count_q <= timer_two_pkg::RESET_COUNT;
            reload_q <= timer_two_pkg::RESET_RELOAD;
        end else begin
            ctl_q <= ctl_d;
            rate_q <= rate_d;
            count_q <= count_d;
            reload_q <= reload_d;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_q <= 4'h0;
            {ct_s1_q, ct_s2_q, ct_s3_q} <= 3'b111;
            {tg_s1_q, tg_s2_q, tg_s3_q} <= 3'b111;
        end else begin
            pre_q <= pre_d;
            {ct_s1_q, ct_s2_q, ct_s3_q} <= {ext_count_input_in, ct_s1_q, ct_s2_q};
            {tg_s1_q, tg_s2_q, tg_s3_q} <= {ext_trigger_input_in, tg_s1_q, tg_s2_q};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {ovf_pulse_q, rx_q, tx_q, t0_q, t1_q} <= 5'b00000;
            rdata_q <= 8'h00;
        end else begin
            ovf_pulse_q <= flag_set;
            rx_q <= rx_d;
            tx_q <= tx_d;
            t0_q <= t0_d;
            t1_q <= t1_d;
            rdata_q <= rd_mux;
        end
    end

    assign sfr_sel_out = sel_any;
    assign sfr_rdata_out = rdata_q;
    assign timer_irq_out = irq_enable_in && (ovf_flag || edge_flag);
    assign overflow_pulse_out = ovf_pulse_q;
    assign rx_shift_clk_out = rx_q;
    assign tx_shift_clk_out = tx_q;
    assign timer0_tick_out = t0_q;
    assign timer1_tick_out = t1_q;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Flag checks
    AST_FLAG_SET: assert property (ovf && !baud |=> ovf_flag)
        else $error("overflow flag not set on overflow");
    AST_FLAG_BAUD: assert property (baud && ovf && !ovf_flag && !wr_ctl |=> !ovf_flag)
        else $error("overflow flag set in baud mode");
    AST_FLAG_HOLD: assert property (ovf_flag && !wr_ctl |=> ovf_flag)
        else $error("overflow flag cleared by hardware");
    AST_FLAG_CLEAR: assert property (wr_ctl && !sfr_wdata_in[7] && !flag_set |=> !ovf_flag)
        else $error("overflow flag not cleared by write");
    AST_FLAG_WRITE: assert property (wr_ctl && sfr_wdata_in[7] |=> ovf_flag)
        else $error("overflow flag not set by write");
    AST_FLAG_IRQ: assert property (ovf_flag && irq_enable_in |-> timer_irq_out)
        else $error("overflow interrupt missing");
    AST_EDGE_FLAG: assert property (edge_hit |=> edge_flag)
        else $error("edge flag not set on trigger edge");
    AST_EDGE_HOLD: assert property (edge_flag && !wr_ctl |=> edge_flag)
        else $error("edge flag cleared by hardware");
    AST_EDGE_IRQ: assert property (edge_flag && irq_enable_in |-> timer_irq_out)
        else $error("edge interrupt missing");

    // Count, overflow pulse, receive pulse and edge flag checks
    AST_INC_STEP: assert property (inc && !ovf && !wr_count && !force_reload
        |=> count_q == $past(count_q) + 16'h0001)
        else $error("count did not step by one");
    AST_ROLL: assert property (ovf && !reload_mode && !wr_count |=> count_q == 16'h0000)
        else $error("count did not roll to zero");
    AST_BAUD_ROLL: assert property (baud && ovf && !wr_count |=> count_q == $past(reload_q))
        else $error("baud overflow did not reload");
    AST_CAPTURE: assert property (capture && !wr_rl && !wr_rh |=> reload_q == $past(count_q))
        else $error("capture did not store count");
    AST_RELOAD_WRITE: assert property (wr_rl |=> reload_q[7:0] == $past(sfr_wdata_in))
        else $error("reload low byte write lost");
    AST_SRC_EDGE: assert property (run && src_sel |-> inc == count_fall)
        else $error("pin count source mismatch");
    AST_FAST: assert property (inc && !src_sel && !baud && upper_fast
        |-> pre_q[1:0] == timer_two_pkg::PRE_FAST_LAST)
        else $error("fast rate mismatch");
    AST_PULSE: assert property (ovf && !baud |=> overflow_pulse_out ##1 !overflow_pulse_out)
        else $error("overflow pulse not one cycle");
    AST_RELOAD: assert property (ovf && reload_mode && !wr_count |=> count_q == $past(reload_q))
        else $error("no reload on overflow");
    AST_FORCE: assert property (force_reload && !wr_count |=> count_q == $past(reload_q))
        else $error("trigger edge did not reload");
    AST_STOP: assert property (!run && !edge_hit && !wr_count |=> $stable(count_q))
        else $error("count moved while stopped");
    AST_SLOW: assert property (inc && !src_sel && !baud && !upper_fast |-> pre_q == 4'hb)
        else $error("slow rate mismatch");
    AST_BAUD2: assert property (run && baud && !src_sel |-> inc == pre_q[0])
        else $error("baud rate not every two clocks");
    AST_RX: assert property (rx_sel && ovf |=> rx_shift_clk_out)
        else $error("receive shift pulse missing");
    AST_EXF: assert property (baud && edge_en && trig_fall
        |=> edge_flag && timer_irq_out == irq_enable_in)
        else $error("edge flag not set");

    // Pulse checks
    AST_TX: assert property (tx_sel && ovf |=> tx_shift_clk_out)
        else $error("transmit shift pulse missing");
    AST_RX_QUIET: assert property (rx_sel && !ovf |=> !rx_shift_clk_out)
        else $error("stray receive shift pulse");
    AST_TX_QUIET: assert property (tx_sel && !ovf |=> !tx_shift_clk_out)
        else $error("stray transmit shift pulse");
    AST_RX_T1: assert property (!rx_sel && timer1_overflow_in |=> rx_shift_clk_out)
        else $error("receive clock not from timer 1");
    AST_TX_T1: assert property (!tx_sel && timer1_overflow_in |=> tx_shift_clk_out)
        else $error("transmit clock not from timer 1");
    AST_NO_PULSE_BAUD: assert property (baud |=> !overflow_pulse_out)
        else $error("overflow pulse in baud mode");
    AST_PULSE_ONLY: assert property (overflow_pulse_out |-> $past(ovf))
        else $error("overflow pulse without overflow");
    AST_T0: assert property (timer0_tick_out |-> $past(t0_fast ? tick4 : tick12))
        else $error("timer 0 tick rate wrong");
    AST_T0_SLOW: assert property (!t0_fast && tick12 |=> timer0_tick_out)
        else $error("timer 0 slow tick missing");
    AST_T1_SLOW: assert property (!t1_fast && tick12 |=> timer1_tick_out)
        else $error("timer 1 slow tick missing");

    // Bus and timer 1 tick checks
    AST_READ_LOW: assert property (sfr_addr_in == timer_two_pkg::ADDR_COUNT_LOW
        |=> sfr_rdata_out == $past(count_q[7:0]))
        else $error("low count read mismatch");
    AST_READ_HIGH: assert property (sfr_addr_in == timer_two_pkg::ADDR_COUNT_HIGH
        |=> sfr_rdata_out == $past(count_q[15:8]))
        else $error("high count read mismatch");
    AST_RATE_WRITE: assert property (wr_rate
        |=> rate_q == ($past(sfr_wdata_in) & timer_two_pkg::RATE_WRITE_MASK))
        else $error("rate select write mismatch");
    AST_T1: assert property (timer1_tick_out |-> $past(t1_fast ? tick4 : tick12))
        else $error("timer 1 tick rate wrong");

    COV_OVF: cover property (ovf && !baud ##1 overflow_pulse_out);
    COV_BAUD: cover property (baud && ovf ##1 tx_shift_clk_out);
    COV_CAPTURE: cover property (capture);
    COV_FORCE: cover property (force_reload);
    COV_EDGE_BAUD: cover property (baud && edge_hit);
endmodule

//--- serial_side_model.sv
// Serial port side model: timer 1 overflow source and shift pulse counters
`timescale 1ns/1ns
module serial_side_model (
    input wire logic clk_in,
    input wire logic t1_run_in,
    input wire logic rx_shift_in,
    input wire logic tx_shift_in,
    output logic t1_ovf_out,
    output int rx_seen_out,
    output int tx_seen_out
);
    int div = 0;
    logic ovf_q = 1'b0;
    int rx_n = 0;
    int tx_n = 0;
    assign t1_ovf_out = ovf_q;
    assign rx_seen_out = rx_n;
    assign tx_seen_out = tx_n;
    // One-cycle timer 1 overflow every 8 clocks
    always @(posedge clk_in) begin
        div <= (div + 1) % 8;
        ovf_q <= t1_run_in && div == 0;
    end
    // Each one-cycle shift pulse counted once
    always @(negedge clk_in) begin
        rx_n <= rx_n + int'(rx_shift_in);
        tx_n <= tx_n + int'(tx_shift_in);
    end
endmodule

//--- timer2_with_rate_control_tb_top.sv
// Self-checking bench for the rate-controlled 16-bit timer
`timescale 1ns/1ns
module timer2_with_rate_control_tb_top;
    localparam logic [7:0] RTE = timer_two_pkg::ADDR_RATE_SELECT;
    localparam logic [7:0] CTL = timer_two_pkg::ADDR_CONTROL;
    localparam logic [7:0] RLL = timer_two_pkg::ADDR_RELOAD_LOW;
    localparam logic [7:0] RLH = timer_two_pkg::ADDR_RELOAD_HIGH;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic cnt_pin = 1'b1;
    logic trg_pin = 1'b1;
    logic irq_en = 1'b0;
    logic t1_run = 1'b0;
    logic sel, irq, ovf, rxs, txs, t0t, t1t, t1o;
    logic [7:0] rdata;
    logic [31:0] lfsr = 32'hd399_41af;
    logic [7:0] regs [6] = '{RTE, RLL, RLH, 8'hcc, 8'hcd, 8'h90};
    int mdl [logic [7:0]];
    int num_errors = 0;
    int compares = 0;
    int rx_seen, tx_seen, a0, a1;
    int t0_n = 0;
    int t1_n = 0;
    timer_two timer_two_i (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_wdata_in(wdata), .sfr_sel_out(sel), .sfr_rdata_out(rdata),
        .ext_count_input_in(cnt_pin), .ext_trigger_input_in(trg_pin), .timer1_overflow_in(t1o),
        .irq_enable_in(irq_en), .timer_irq_out(irq), .overflow_pulse_out(ovf),
        .rx_shift_clk_out(rxs), .tx_shift_clk_out(txs), .timer0_tick_out(t0t),
        .timer1_tick_out(t1t));
    serial_side_model serial_side_model_i (.clk_in(clk_in), .t1_run_in(t1_run),
        .rx_shift_in(rxs), .tx_shift_in(txs), .t1_ovf_out(t1o), .rx_seen_out(rx_seen),
        .tx_seen_out(tx_seen));
    initial forever #10 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        t0_n <= t0_n + int'(t0t);
        t1_n <= t1_n + int'(t1t);
    end
    function automatic logic [31:0] nxt(input logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        mdl[a] = int'(d);
        if (a == RTE) mdl[a] = int'(d & timer_two_pkg::RATE_WRITE_MASK);
        if (a == 8'h90) mdl[a] = 0;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        addr = a;
        @(negedge clk_in);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic set_count(input logic [15:0] v);
        wr_reg(8'hcc, v[7:0]);
        wr_reg(8'hcd, v[15:8]);
    endtask
    task automatic rd_count(input logic [15:0] v);
        rd_chk(8'hcc, v[7:0]);
        rd_chk(8'hcd, v[15:8]);
    endtask
    task automatic wait_ovf();
        for (int i = 0; i < 200 && ovf !== 1'b1; i++) @(negedge clk_in);
        chk({15'h0000, ovf}, 16'h0001);
    endtask
    task automatic close_out();
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
    initial begin
        foreach (regs[k]) mdl[regs[k]] = 0;
        cycles(12);
        rst_in = 1'b0;
        rd_chk(CTL, 8'h00);
        foreach (regs[k]) rd_chk(regs[k], 8'h00);
        chk({15'h0000, sel}, 16'h0000);
        for (int p = 0; p < 2; p++) foreach (regs[k]) begin
            lfsr = nxt(lfsr);
            wr_reg(regs[k], lfsr[7:0]);
            rd_chk(regs[k], 8'(mdl[regs[k]]));
        end
        for (int m = 0; m < 2; m++) begin
            wr_reg(RTE, m ? 8'h38 : 8'h00);
            set_count(16'h0000);
            wr_reg(CTL, 8'h05);
            cycles(118);
            wr_reg(CTL, 8'h01);
            rd_count(m ? 16'h001e : 16'h000a);
            a0 = t0_n;
            a1 = t1_n;
            cycles(120);
            chk(16'(t0_n - a0), m ? 16'h001e : 16'h000a);
            chk(16'(t1_n - a1), m ? 16'h001e : 16'h000a);
        end
        wr_reg(RTE, 8'h00);
        chk({15'h0000, irq}, 16'h0000);
        irq_en = 1'b1;
        set_count(16'hfffe);
        wr_reg(CTL, 8'h05);
        wait_ovf();
        cycles(1);
        chk({15'h0000, ovf}, 16'h0000);
        wr_reg(CTL, 8'h81);
        rd_count(16'h0000);
        rd_chk(CTL, 8'h81);
        chk({15'h0000, sel}, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(CTL, 8'h01);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(CTL, 8'h80);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(RLL, 8'h34);
        wr_reg(RLH, 8'h12);
        set_count(16'hffff);
        wr_reg(CTL, 8'h04);
        wait_ovf();
        wr_reg(CTL, 8'h80);
        rd_count(16'h1234);
        cycles(30);
        rd_count(16'h1234);
        wr_reg(CTL, 8'h08);
        set_count(16'h0000);
        trg_pin = 1'b0;
        cycles(6);
        rd_chk(CTL, 8'h48);
        rd_count(16'h1234);
        trg_pin = 1'b1;
        set_count(16'h0000);
        for (int m = 0; m < 2; m++) begin
            wr_reg(CTL, m ? 8'h03 : 8'h07);
            repeat (5) begin
                cnt_pin = 1'b0;
                cycles(4);
                cnt_pin = 1'b1;
                cycles(4);
            end
            rd_count(16'h0005);
        end
        wr_reg(RTE, 8'h20);
        wr_reg(RLL, 8'hfe);
        wr_reg(RLH, 8'hff);
        set_count(16'hfffe);
        t1_run = 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr_reg(CTL, m ? 8'h14 : 8'h24);
            cycles(8);
            a0 = rx_seen;
            a1 = tx_seen;
            cycles(40);
            chk(16'(rx_seen - a0), m ? 16'h0005 : 16'h000a);
            chk(16'(tx_seen - a1), m ? 16'h000a : 16'h0005);
            rd_chk(CTL, m ? 8'h14 : 8'h24);
        end
        wr_reg(CTL, 8'h1c);
        chk({15'h0000, irq}, 16'h0000);
        trg_pin = 1'b0;
        cycles(6);
        rd_chk(CTL, 8'h5c);
        chk({15'h0000, irq}, 16'h0001);
        close_out();
    end
endmodule
